//--- serial_port_four_mode.sv
/*
  Four-mode full-duplex serial port: control and data registers on the
  core's special function register port, mode 0 shift engine, framed
  transmitter, and hookup of the rate generator and framed receiver.
  Assumes the register port and all pins are synchronous to clk; timer
  reload values and the doubling bit come from registers outside.
*/
// Contract
// [R1] full duplex, one received byte buffered
// [R2] buffer write feeds transmit, read returns receive
// [R3] mode 0 shifts eight bits, clock/6
// [R4] mode 1 ten-bit frame, stop to ninth flag
// [R5] modes 2/3 eleven bits, ninth bit fields
// [R6] mode 2 rate clock*2^doubling/32
// [R7] mode 3 like mode 2, timer rate
// [R8] mode select 00,01,11 give modes 0,1,3
// [R9] mode select 10 gives mode 2
// [R10] buffer write starts transmission, every mode; mode 0 drops a write while the shift engine is busy
// [R11] mode 0 receive when flag clear, enabled
// [R12] framed receive starts on start bit, enabled
// [R13] filter: modes 2/3 flag only if ninth set
// [R14] filter mode 1 needs valid stop; none mode 0
// [R15] address bytes ninth one, data bytes zero
// [R16] timer 1 rate 2^doubling/32 of overflow
// [R17] software keeps timer 1 in auto-reload
// [R18] timer 2 clock selects give baud generator
// [R19] external timer 2 count: overflow over 16
// [R20] done flags set by hardware, cleared by software
`timescale 1ns/1ns
module serial_port_four_mode (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       baud_doubling_bit,
  input  wire logic [7:0] timer1_reload_byte,
  input  wire logic [7:0] timer2_count_high,
  input  wire logic [7:0] timer2_count_low,
  input  wire logic       receive_clock_select,
  input  wire logic       transmit_clock_select,
  input  wire logic       timer2_counter_mode,
  input  wire logic       timer2_count_input,
  output logic            tx_line,
  input  wire logic       rx_line_in,
  output logic            rx_line_out,
  output logic            rx_line_oe_n,
  output logic            serial_irq
);
  // register state
  logic [7:0] ctrl_r;
  logic [7:0] rx_buf_r;
  logic [7:0] rdata_r;
  logic       irq_r;
  logic       tx_line_r;
  logic       rx_out_r;
  logic       rx_oe_n_r;

  // mode 0 engine
  serial_port_pkg::shift_state_type sh_r;
  logic [2:0] phase_r;
  logic [3:0] sh_cnt_r;
  logic [7:0] sh_reg_r;

  // framed transmitter
  logic        atx_busy_r;
  logic [3:0]  atx_cnt_r;
  logic [3:0]  atx_left_r;
  logic [10:0] atx_shift_r;

  // events and decodes
  serial_port_pkg::mode_type mode;
  logic       nine;
  logic       wr_ctrl;
  logic       wr_data;
  logic       tx_tick;
  logic       rx_tick;
  logic       arx_done;
  logic [7:0] arx_data;
  logic       arx_ninth;
  logic       sh_step;
  logic       m0_tx_done;
  logic       m0_rx_done;
  logic       atx_done;
  logic       tx_done;
  logic       arx_accept;
  logic       rx_load;
  logic [7:0] rx_byte;

  localparam logic [3:0] SHIFT_CNT_LAST = serial_port_pkg::SHIFT_BITS - 4'h1;

  function automatic serial_port_pkg::mode_type decode_mode(input logic [7:0] c);
    decode_mode = serial_port_pkg::mode_type'({c[serial_port_pkg::BIT_MODE_HI],
                                                c[serial_port_pkg::BIT_MODE_LO]}); // R8 R9
  endfunction

  function automatic logic nine_bit_mode(input logic [7:0] c);
    nine_bit_mode = c[serial_port_pkg::BIT_MODE_HI]; // R5 R9
  endfunction

  assign mode    = decode_mode(ctrl_r);
  assign nine    = nine_bit_mode(ctrl_r);
  assign wr_ctrl = sfr_wr && (sfr_addr == serial_port_pkg::CTRL_ADDR);
  assign wr_data = sfr_wr && (sfr_addr == serial_port_pkg::DATA_ADDR);

  assign sfr_rdata    = rdata_r;
  assign serial_irq   = irq_r;
  assign tx_line      = tx_line_r;
  assign rx_line_out  = rx_out_r;
  assign rx_line_oe_n = rx_oe_n_r;

  serial_rate_gen u_rate (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .baud_doubling_bit     (baud_doubling_bit),
    .fixed_rate            (mode == serial_port_pkg::MODE_ASYNC9_FIXED),
    .timer2_counter_mode   (timer2_counter_mode),
    .timer2_count_input    (timer2_count_input),
    .receive_clock_select  (receive_clock_select),
    .transmit_clock_select (transmit_clock_select),
    .timer1_reload_byte    (timer1_reload_byte),
    .timer2_count_high     (timer2_count_high),
    .timer2_count_low      (timer2_count_low),
    .tx_tick               (tx_tick),
    .rx_tick               (rx_tick)
  );

  serial_async_rx u_rx (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .tick      (rx_tick),
    .enable    (ctrl_r[serial_port_pkg::BIT_RX_EN] && mode != serial_port_pkg::MODE_SHIFT), // R12
    .nine_bits (nine),
    .rxd       (rx_line_in),
    .done      (arx_done),
    .data      (arx_data),
    .ninth     (arx_ninth)
  );

  // receive and transmit completion; in mode 1 the ninth field holds the stop bit
  assign sh_step    = (phase_r == serial_port_pkg::SHIFT_LAST);
  assign m0_tx_done = (sh_r == serial_port_pkg::SH_TX) && sh_step && (sh_cnt_r == SHIFT_CNT_LAST);
  assign m0_rx_done = (sh_r == serial_port_pkg::SH_RX) && sh_step && (sh_cnt_r == SHIFT_CNT_LAST);
  assign arx_accept = arx_done && mode != serial_port_pkg::MODE_SHIFT
                      && !ctrl_r[serial_port_pkg::BIT_RX_DONE]
                      && (!ctrl_r[serial_port_pkg::BIT_FILTER] || arx_ninth); // R13 R14 R15
  assign rx_load    = m0_rx_done || arx_accept; // R14
  assign rx_byte    = m0_rx_done ? {rx_line_in, sh_reg_r[7:1]} : arx_data;
  assign atx_done   = atx_busy_r && tx_tick && (atx_cnt_r == serial_port_pkg::TICK_LAST) && (atx_left_r == 4'h1);
  assign tx_done    = m0_tx_done || atx_done;

  // control register: hardware sets written after software so the set wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= serial_port_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= sfr_wdata;
      end
      if (tx_done) begin
        ctrl_r[serial_port_pkg::BIT_TX_DONE] <= 1'b1; // R20
      end
      if (rx_load) begin
        ctrl_r[serial_port_pkg::BIT_RX_DONE] <= 1'b1; // R20
      end
      if (arx_accept) begin
        ctrl_r[serial_port_pkg::BIT_RX_NINTH] <= arx_ninth; // R4 R5
      end
    end
  end

  // receive buffer is separate from both shifters
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_buf_r <= 8'h00;
    end else if (rx_load) begin
      rx_buf_r <= rx_byte; // R1 R2
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        serial_port_pkg::CTRL_ADDR: rdata_r <= ctrl_r;
        serial_port_pkg::DATA_ADDR: rdata_r <= rx_buf_r; // R2
        default:                    rdata_r <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ctrl_r[serial_port_pkg::BIT_TX_DONE] || ctrl_r[serial_port_pkg::BIT_RX_DONE]; // R20
    end
  end

  // mode 0 engine: transmit has priority over a pending receive start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sh_r     <= serial_port_pkg::SH_IDLE;
      phase_r  <= 3'h0;
      sh_cnt_r <= 4'h0;
      sh_reg_r <= 8'h00;
    end else if (mode != serial_port_pkg::MODE_SHIFT) begin
      sh_r <= serial_port_pkg::SH_IDLE;
    end else begin
      case (sh_r)
        serial_port_pkg::SH_IDLE: begin
          phase_r  <= 3'h0;
          sh_cnt_r <= 4'h0;
          if (wr_data) begin
            sh_r     <= serial_port_pkg::SH_TX; // R10
            sh_reg_r <= sfr_wdata;
          end else if (ctrl_r[serial_port_pkg::BIT_RX_EN] && !ctrl_r[serial_port_pkg::BIT_RX_DONE]) begin
            sh_r <= serial_port_pkg::SH_RX; // R11
          end
        end
        serial_port_pkg::SH_TX, serial_port_pkg::SH_RX: begin
          phase_r <= sh_step ? 3'h0 : phase_r + 3'h1; // R3
          if (sh_step) begin
            sh_reg_r <= {(sh_r == serial_port_pkg::SH_RX) && rx_line_in, sh_reg_r[7:1]}; // R3
            sh_cnt_r <= sh_cnt_r + 4'h1;
            if (sh_cnt_r == SHIFT_CNT_LAST) begin
              sh_r <= serial_port_pkg::SH_IDLE;
            end
          end
        end
        default: sh_r <= serial_port_pkg::SH_IDLE;
      endcase
    end
  end

  // framed transmitter; a write while busy restarts the frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      atx_busy_r  <= 1'b0;
      atx_cnt_r   <= 4'h0;
      atx_left_r  <= 4'h0;
      atx_shift_r <= 11'h7FF;
    end else if (wr_data && mode != serial_port_pkg::MODE_SHIFT) begin
      atx_busy_r  <= 1'b1; // R10
      atx_cnt_r   <= 4'h0;
      atx_left_r  <= nine ? serial_port_pkg::FRAME_BITS_9 : serial_port_pkg::FRAME_BITS_8; // R4 R5
      atx_shift_r <= {1'b1, !nine || ctrl_r[serial_port_pkg::BIT_TX_NINTH], sfr_wdata, 1'b0}; // R4 R5 R15
    end else if (atx_busy_r && tx_tick) begin
      atx_cnt_r <= atx_cnt_r + 4'h1;
      if (atx_cnt_r == serial_port_pkg::TICK_LAST) begin
        atx_shift_r <= {1'b1, atx_shift_r[10:1]};
        atx_left_r  <= atx_left_r - 4'h1;
        if (atx_left_r == 4'h1) begin
          atx_busy_r <= 1'b0;
        end
      end
    end
  end

  // pins: mode 0 clock low for the first half of each bit, data out on the receive line
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_line_r <= 1'b1;
      rx_out_r  <= 1'b1;
      rx_oe_n_r <= 1'b1;
    end else begin
      if (sh_r != serial_port_pkg::SH_IDLE) begin
        tx_line_r <= (phase_r >= serial_port_pkg::SHIFT_HALF); // R3
      end else if (atx_busy_r) begin
        tx_line_r <= atx_shift_r[0];
      end else begin
        tx_line_r <= 1'b1;
      end
      rx_out_r  <= (sh_r == serial_port_pkg::SH_TX) ? sh_reg_r[0] : 1'b1; // R3
      rx_oe_n_r <= (sh_r != serial_port_pkg::SH_TX);
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [7:0] chk_ticks_r;
  always_ff @(posedge clk) begin
    if (sys_rst || wr_data) begin
      chk_ticks_r <= 8'h00;
    end else if (atx_busy_r && tx_tick) begin
      chk_ticks_r <= chk_ticks_r + 8'h01;
    end
  end

  sequence shift_clk_low;
    !tx_line_r [*3];
  endsequence

  sequence shift_clk_high;
    tx_line_r [*3];
  endsequence

  shift_clock_a: assert property ( // R3
    $fell(tx_line_r) && sh_r != serial_port_pkg::SH_IDLE && mode == serial_port_pkg::MODE_SHIFT
    |-> shift_clk_low ##1 shift_clk_high) else $error("shift clock phases wrong");

  shift_drive_a: assert property ( // R3
    sh_r == serial_port_pkg::SH_TX && $past(sh_r) == serial_port_pkg::SH_TX |-> !rx_oe_n_r)
    else $error("receive line not driven in shift transmit");

  buf_write_a: assert property ( // R10
    wr_data && mode != serial_port_pkg::MODE_SHIFT |=> atx_busy_r ##1 !tx_line_r)
    else $error("buffer write did not start frame");

  frame_len_a: assert property ( // R5
    atx_done && !wr_data |-> chk_ticks_r == (nine ? 8'hAF : 8'h9F))
    else $error("frame length wrong for mode");

  stop_bit_a: assert property ( // R4
    atx_busy_r && atx_left_r == 4'h1 |-> atx_shift_r[0])
    else $error("stop bit not high");

  mode2_map_a: assert property ( // R9
    wr_data && ctrl_r[7:6] == 2'b10 |=> atx_left_r == serial_port_pkg::FRAME_BITS_9)
    else $error("mode select 10 not eleven-bit frame");

  shift_rx_start_a: assert property ( // R11
    mode == serial_port_pkg::MODE_SHIFT && sh_r == serial_port_pkg::SH_IDLE && !wr_data && !wr_ctrl
    && ctrl_r[serial_port_pkg::BIT_RX_EN] && !ctrl_r[serial_port_pkg::BIT_RX_DONE]
    |=> sh_r == serial_port_pkg::SH_RX) else $error("shift receive did not start");

  filter_drop_a: assert property ( // R13
    arx_done && mode != serial_port_pkg::MODE_SHIFT && ctrl_r[serial_port_pkg::BIT_FILTER] && !arx_ninth
    && !wr_ctrl |=> $stable(ctrl_r[serial_port_pkg::BIT_RX_DONE]) && $stable(rx_buf_r))
    else $error("filtered byte was accepted");

  set_wins_a: assert property ( // R20
    rx_load && wr_ctrl && !sfr_wdata[serial_port_pkg::BIT_RX_DONE] |=> ctrl_r[serial_port_pkg::BIT_RX_DONE])
    else $error("software clear beat hardware set");

  flag_hold_a: assert property ( // R20
    ctrl_r[serial_port_pkg::BIT_RX_DONE] && !wr_ctrl |=> ctrl_r[serial_port_pkg::BIT_RX_DONE] ##1 irq_r)
    else $error("receive flag or interrupt dropped");

  rx_read_a: assert property ( // R2
    sfr_rd && sfr_addr == serial_port_pkg::DATA_ADDR |=> sfr_rdata == $past(rx_buf_r))
    else $error("buffer read not receive register");
endmodule // serial_port_four_mode

//--- serial_port_pkg.sv
/*
  Shared constants and types for the four-mode serial port: register
  addresses, control field positions, reset value, divider counts and the
  mode and state enumerations. Assumes a single 100 MHz core clock.
*/
package serial_port_pkg;

  // special function register addresses
  localparam logic [7:0] CTRL_ADDR  = 8'h99;
  localparam logic [7:0] DATA_ADDR  = 8'h9A;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // control register fields
  localparam int BIT_MODE_HI  = 7;
  localparam int BIT_MODE_LO  = 6;
  localparam int BIT_FILTER   = 5;
  localparam int BIT_RX_EN    = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE  = 1;
  localparam int BIT_RX_DONE  = 0;

  // shift register mode: one bit every six clocks, clock low for the first half
  localparam int         SHIFT_DIV  = 6;
  localparam logic [2:0] SHIFT_LAST = 3'(SHIFT_DIV - 1);
  localparam logic [2:0] SHIFT_HALF = 3'(SHIFT_DIV / 2);
  localparam logic [3:0] SHIFT_BITS = 4'h8;

  // asynchronous framing: sixteen rate ticks per bit
  localparam logic [3:0] TICK_LAST    = 4'hF;
  localparam logic [3:0] TICK_MID     = 4'h7;
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] SAMPLE_LAST8 = 4'h8;
  localparam logic [3:0] SAMPLE_LAST9 = 4'h9;

  // timer 1 counts once every six clocks
  localparam logic [2:0] T1_PRESCALE_LAST = 3'h5;

  typedef enum logic [1:0] {MODE_SHIFT, MODE_ASYNC8, MODE_ASYNC9_FIXED, MODE_ASYNC9_TIMER} mode_type;
  typedef enum logic [1:0] {SH_IDLE, SH_TX, SH_RX} shift_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_type;

endpackage

//--- serial_rate_gen.sv
/*
  Bit rate sources: timer 1 in 8-bit auto-reload, timer 2 in baud generator
  mode (internal clock or external count pin) and the fixed mode 2 divider.
  Produces one tick per sixteenth of a bit for each direction. The count pin
  is taken as synchronous to clk.
*/
`timescale 1ns/1ns
module serial_rate_gen (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       baud_doubling_bit,
  input  wire logic       fixed_rate,
  input  wire logic       timer2_counter_mode,
  input  wire logic       timer2_count_input,
  input  wire logic       receive_clock_select,
  input  wire logic       transmit_clock_select,
  input  wire logic [7:0] timer1_reload_byte,
  input  wire logic [7:0] timer2_count_high,
  input  wire logic [7:0] timer2_count_low,
  output logic            tx_tick,
  output logic            rx_tick
);
  logic [2:0]  pre_r;
  logic [7:0]  t1_r;
  logic [15:0] t2_r;
  logic        t1_half_r;
  logic        fix_half_r;
  logic        t2_in_d_r;
  logic        t1_ov;
  logic        t2_ov;
  logic        t2_step;
  logic        t1_tick;
  logic        fixed_tick;

  assign t1_ov      = (pre_r == serial_port_pkg::T1_PRESCALE_LAST) && (t1_r == 8'hFF);
  assign t2_step    = timer2_counter_mode ? (timer2_count_input && !t2_in_d_r) : 1'b1; // R19
  assign t2_ov      = t2_step && (t2_r == 16'hFFFF);
  assign t1_tick    = t1_ov && (baud_doubling_bit || t1_half_r); // R16
  assign fixed_tick = baud_doubling_bit || fix_half_r; // R6
  assign rx_tick    = fixed_rate ? fixed_tick : (receive_clock_select ? t2_ov : t1_tick); // R7 R18
  assign tx_tick    = fixed_rate ? fixed_tick : (transmit_clock_select ? t2_ov : t1_tick); // R7 R18

  always_ff @(posedge clk) begin
    if (sys_rst || pre_r == serial_port_pkg::T1_PRESCALE_LAST) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t1_r      <= 8'h00;
      t1_half_r <= 1'b0;
    end else if (pre_r == serial_port_pkg::T1_PRESCALE_LAST) begin
      t1_r <= t1_ov ? timer1_reload_byte : t1_r + 8'h01; // R16
      if (t1_ov) begin
        t1_half_r <= !t1_half_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t2_r      <= 16'h0000;
      t2_in_d_r <= 1'b0;
    end else begin
      t2_in_d_r <= timer2_count_input;
      if (t2_step) begin
        t2_r <= t2_ov ? {timer2_count_high, timer2_count_low} : t2_r + 16'h0001; // R18
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fix_half_r <= 1'b0;
    end else begin
      fix_half_r <= !fix_half_r;
    end
  end
endmodule // serial_rate_gen

//--- serial_async_rx.sv
/*
  Receiver for the framed modes: start detection, mid-bit sampling at
  sixteen ticks per bit, eight data bits then either the stop bit or a ninth
  bit. Assumes rxd synchronous to clk and the tick from serial_rate_gen.
*/
`timescale 1ns/1ns
module serial_async_rx (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic       nine_bits,
  input  wire logic       rxd,
  output logic            done,
  output logic [7:0]      data,
  output logic            ninth
);
  serial_port_pkg::rx_state_type st_r;
  logic [3:0] cnt_r;
  logic [3:0] bits_r;
  logic [8:0] shreg_r;
  logic       rxd_d_r;
  logic       done_r;
  logic [3:0] last;

  assign last  = nine_bits ? serial_port_pkg::SAMPLE_LAST9 : serial_port_pkg::SAMPLE_LAST8;
  assign done  = done_r;
  assign data  = shreg_r[7:0];
  assign ninth = shreg_r[8];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r    <= serial_port_pkg::RX_IDLE;
      cnt_r   <= 4'h0;
      bits_r  <= 4'h0;
      shreg_r <= 9'h000;
      rxd_d_r <= 1'b1;
      done_r  <= 1'b0;
    end else begin
      rxd_d_r <= rxd;
      done_r  <= 1'b0;
      if (!enable) begin
        st_r <= serial_port_pkg::RX_IDLE;
      end else begin
        case (st_r)
          serial_port_pkg::RX_IDLE: begin
            cnt_r <= 4'h0;
            if (rxd_d_r && !rxd) begin
              st_r <= serial_port_pkg::RX_START; // R12
            end
          end
          serial_port_pkg::RX_START: begin
            if (tick) begin
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == serial_port_pkg::TICK_MID) begin
                cnt_r  <= 4'h0;
                bits_r <= 4'h0;
                st_r   <= rxd ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
              end
            end
          end
          serial_port_pkg::RX_DATA: begin
            if (tick) begin
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == serial_port_pkg::TICK_LAST) begin
                bits_r <= bits_r + 4'h1;
                if (bits_r != serial_port_pkg::SAMPLE_LAST9) begin
                  shreg_r <= {rxd, shreg_r[8:1]}; // R4 R5
                end
                if (bits_r == last) begin
                  done_r <= 1'b1;
                  st_r   <= serial_port_pkg::RX_IDLE;
                end
              end
            end
          end
          default: st_r <= serial_port_pkg::RX_IDLE;
        endcase
      end
    end
  end
endmodule // serial_async_rx

//--- serial_node_model.sv
/*
  Remote serial node on the far side of the port: sends and captures framed
  bits and serves the shift-register mode. Assumes the bench clk and bit
  periods given in clk cycles; its line idles high like a pulled-up wire.
*/
`timescale 1ns/1ns
module serial_node_model (
  input  wire logic clk,
  input  wire logic tx_line,
  input  wire logic rx_wire,
  output logic      node_drive
);
  initial node_drive = 1'b1;

  task automatic wait_tx(input logic v, output bit ok);
    int t;
    t = 0;
    while (tx_line !== v && t < 4000) begin
      @(negedge clk);
      t++;
    end
    ok = (t < 4000);
  endtask

  // bit 0 goes first, each held for one period
  task automatic send_bits(input logic [10:0] bits, input int n, input int period);
    for (int i = 0; i < n; i++) begin
      node_drive = bits[i];
      repeat (period) @(negedge clk);
    end
    node_drive = 1'b1;
  endtask

  // sample mid-bit from the falling start edge
  task automatic get_bits(output logic [10:0] bits, input int n, input int period);
    bit ok;
    bits = '0;
    wait_tx(1'b0, ok);
    if (!ok) bits = 'x;
    repeat (period / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = ok ? tx_line : 1'bx;
      repeat (period) @(negedge clk);
    end
  endtask

  // new bit after each falling shift clock, capture on the rising one
  task automatic shift_bits(input logic [7:0] out_byte, output logic [10:0] in_bits);
    bit ok;
    bit ok2;
    in_bits = '0;
    for (int i = 0; i < 8; i++) begin
      wait_tx(1'b0, ok);
      node_drive = out_byte[i];
      wait_tx(1'b1, ok2);
      in_bits[i] = (ok && ok2) ? rx_wire : 1'bx;
    end
    // hold the last bit past the port's sampling edge
    repeat (3) @(negedge clk);
    node_drive = 1'b1;
  endtask
endmodule // serial_node_model

//--- serial_port_four_mode_tb.sv
/*
  Self-checking bench for the four-mode serial port: register read and
  write tasks, and a remote node model on the lines. Assumes 100 MHz clk
  and synchronous active-high reset.
*/
`timescale 1ns/1ns
module serial_port_four_mode_tb;
  logic        clk, sys_rst, sfr_wr, sfr_rd, baud_doubling_bit, serial_irq;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rd_v;
  logic [7:0]  timer1_reload_byte, timer2_count_high, timer2_count_low;
  logic        receive_clock_select, transmit_clock_select, timer2_counter_mode, timer2_count_input;
  logic        tx_line, rx_line_in, rx_line_out, rx_line_oe_n, node_drive;
  logic [10:0] got;
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;
  localparam logic [7:0] CA = serial_port_pkg::CTRL_ADDR;
  localparam logic [7:0] DA = serial_port_pkg::DATA_ADDR;

  // wire level of the shared receive pin
  assign rx_line_in = rx_line_oe_n ? node_drive : rx_line_out;
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  serial_port_four_mode DUT (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .baud_doubling_bit(baud_doubling_bit),
    .timer1_reload_byte(timer1_reload_byte), .timer2_count_high(timer2_count_high),
    .timer2_count_low(timer2_count_low), .receive_clock_select(receive_clock_select),
    .transmit_clock_select(transmit_clock_select), .timer2_counter_mode(timer2_counter_mode),
    .timer2_count_input(timer2_count_input), .tx_line(tx_line), .rx_line_in(rx_line_in),
    .rx_line_out(rx_line_out), .rx_line_oe_n(rx_line_oe_n), .serial_irq(serial_irq));
  serial_node_model node (.clk(clk), .tx_line(tx_line), .rx_wire(rx_line_in), .node_drive(node_drive));

  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    @(negedge clk);
    rd_v = sfr_rdata;
  endtask

  task automatic complete_run();
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    baud_doubling_bit = 1'b1;
    timer1_reload_byte = 8'hFF;
    timer2_count_high = 8'hFF;
    timer2_count_low = 8'hF0;
    receive_clock_select = 1'b0;
    transmit_clock_select = 1'b0;
    timer2_counter_mode = 1'b0;
    timer2_count_input = 1'b0;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    rd(CA);
    chk("ctrl reset", {3'h0, rd_v}, 11'h000);
    rd(8'h98);
    chk("unmapped", {3'h0, rd_v}, 11'h000);
    // shift mode transmit, then receive
    fork
      node.shift_bits(8'h00, got);
      wr(DA, 8'h3C);
    join
    chk("shift tx", got, 11'h03C);
    repeat (8) @(negedge clk);
    rd(CA);
    chk("ctrl shift tx", {3'h0, rd_v}, 11'h002);
    chk("irq", {10'h0, serial_irq}, 11'h001);
    fork
      node.shift_bits(8'h96, got);
      wr(CA, 8'h10);
    join
    repeat (8) @(negedge clk);
    rd(CA);
    chk("ctrl shift rx", {3'h0, rd_v}, 11'h011);
    rd(DA);
    chk("shift rx data", {3'h0, rd_v}, 11'h096);
    // fixed-rate eleven-bit frames, sixteen clocks per bit
    wr(CA, 8'h88);
    fork
      node.get_bits(got, 11, 16);
      wr(DA, 8'hA5);
    join
    chk("mode2 frame", got, {1'b1, 1'b1, 8'hA5, 1'b0});
    rd(CA);
    chk("ctrl mode2 tx", {3'h0, rd_v}, 11'h08A);
    wr(CA, 8'hB0);
    node.send_bits({1'b1, 1'b0, 8'h5A, 1'b0}, 11, 16);
    rd(CA);
    chk("data byte filtered", {3'h0, rd_v}, 11'h0B0);
    node.send_bits({1'b1, 1'b1, 8'hC3, 1'b0}, 11, 16);
    rd(CA);
    chk("address byte", {3'h0, rd_v}, 11'h0B5);
    chk("irq rx", {10'h0, serial_irq}, 11'h001);
    rd(DA);
    chk("address data", {3'h0, rd_v}, 11'h0C3);
    // timer 1 auto-reload rate: 2*16*6*(256-255) clocks per bit
    // timer 1 counts up from zero after reset and first overflows near 1540 clocks
    repeat (1600 - cyc) @(negedge clk);
    baud_doubling_bit = 1'b0;
    wr(CA, 8'h50);
    fork
      node.get_bits(got, 10, 192);
      node.send_bits({2'b11, 8'h6E, 1'b0}, 10, 192);
      wr(DA, 8'h81);
    join
    chk("mode1 frame", got, {2'b01, 8'h81, 1'b0});
    rd(CA);
    chk("ctrl mode1", {3'h0, rd_v}, 11'h057);
    rd(DA);
    chk("mode1 rx data", {3'h0, rd_v}, 11'h06E);
    wr(CA, 8'h70);
    node.send_bits({2'b00, 8'h33, 1'b0}, 10, 192);
    rd(CA);
    chk("bad stop filtered", {3'h0, rd_v}, 11'h070);
    wr(CA, 8'hC0);
    fork
      node.get_bits(got, 11, 192);
      wr(DA, 8'h0F);
    join
    chk("mode3 frame", got, {1'b1, 1'b0, 8'h0F, 1'b0});
    // timer 2 first overflows 65536 clocks after reset, then every 16: 256 clocks per bit
    repeat (65600 - cyc) @(negedge clk);
    transmit_clock_select = 1'b1;
    receive_clock_select = 1'b1;
    wr(CA, 8'hD0);
    fork
      node.get_bits(got, 11, 256);
      node.send_bits({1'b1, 1'b1, 8'h4B, 1'b0}, 11, 256);
      wr(DA, 8'h5C);
    join
    chk("timer2 frame", got, {1'b1, 1'b0, 8'h5C, 1'b0});
    rd(CA);
    chk("ctrl timer2", {3'h0, rd_v}, 11'h0D7);
    rd(DA);
    chk("timer2 rx data", {3'h0, rd_v}, 11'h04B);
    complete_run();
  end
endmodule // serial_port_four_mode_tb
